// >>> rtl/erm_pkg.sv
package erm_pkg;

    // memory modes, fixed at build time
    typedef enum logic [2:0] {
        ERM_SP,
        ERM_SDP,
        ERM_TDP,
        ERM_SHIFT,
        ERM_ROM,
        ERM_FIFO
    } erm_mode_t;

    // physical block flavours
    typedef enum logic [1:0] {
        ERM_LARGE,
        ERM_MEDIUM,
        ERM_LUT
    } erm_blk_t;

    // read-during-write output choice
    typedef enum logic [1:0] {
        ERM_RDW_NEW,
        ERM_RDW_OLD,
        ERM_RDW_DC
    } erm_rdw_t;

    // apb register byte offsets
    localparam logic [11:0] ERM_CTRL_OFF = 12'h000;
    localparam logic [11:0] ERM_STAT_OFF = 12'h004;
    localparam logic [11:0] ERM_CNT_OFF = 12'h008;

    // control fields and reset value
    localparam int ERM_CTRL_OREG_BIT = 0;
    localparam int ERM_CTRL_RDW_LSB = 1;
    localparam logic [31:0] ERM_CTRL_RST = 32'h0000_0001;

    // status fields
    localparam int ERM_STAT_MODE_LSB = 0;
    localparam int ERM_STAT_BLK_LSB = 4;
    localparam int ERM_STAT_ERR_BIT = 8;
    localparam int ERM_STAT_LVL_LSB = 16;

    // counter fields
    localparam int ERM_CNT_RD_LSB = 16;

    // fifo depth and rom image seed
    localparam int ERM_FIFO_DEPTH = 8;
    localparam logic [31:0] ERM_ROM_SEED = 32'h5a5a_5a5a;

endpackage : erm_pkg

// >>> rtl/erm_stream_if.sv
`timescale 1ns/1ps
// valid/ready word stream between the top and its fifo
interface erm_stream_if #(
    parameter int W = 16
) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : erm_stream_if

// >>> rtl/erm_fifo.sv
`timescale 1ns/1ps
module erm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic pclk,                 // clock
    input wire logic presetn,              // async reset, active low
    erm_stream_if.snk wr,                  // fill side
    erm_stream_if.src rd,                  // drain side
    output logic [$clog2(DEPTH):0] level   // words held
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    wire push;
    wire pop;

    ////////////////////////////////////////////////////////////////////
    // handshakes and flags
    assign wr.ready = (count != FULL);
    assign rd.valid = (count != '0);
    assign rd.data = store[rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;
    assign level = count;

    ////////////////////////////////////////////////////////////////////
    // pointers and occupancy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            if (push) wp <= (wp == LAST) ? '0 : wp + 1'b1;
            if (pop) rp <= (rp == LAST) ? '0 : rp + 1'b1;
            if (push && !pop) count <= count + 1'b1;
            else if (pop && !push) count <= count - 1'b1;
        end
    end

    // storage write
    always_ff @(posedge pclk) begin
        if (push) store[wp] <= wr.data;
    end

endmodule : erm_fifo

// >>> rtl/erm_top.sv
`timescale 1ns/1ps
module erm_top #(
    parameter erm_pkg::erm_mode_t MODE = erm_pkg::ERM_SP,
    parameter erm_pkg::erm_blk_t BLOCK = erm_pkg::ERM_LARGE,
    parameter int WIDTH = 16,
    parameter int DEPTH = 32,
    parameter bit HAS_RDEN = 1'b1,
    parameter bit ROM_ADDR_UNREG = 1'b0,
    parameter int TAP_LEN = 4,
    parameter int TAPS = 4,
    parameter int FIFO_RD_W = 16,
    parameter logic [WIDTH-1:0] DC_WORD = '1
) (
    input wire logic pclk,                  // clock
    input wire logic presetn,               // async reset, active low
    input wire logic out_aclr,              // async clear of output registers
    input wire logic psel,                  // apb select
    input wire logic penable,               // apb enable
    input wire logic pwrite,                // apb direction
    input wire logic [11:0] paddr,          // apb address
    input wire logic [31:0] pwdata,         // apb write data
    output logic [31:0] prdata,             // apb read data
    output logic pready,                    // apb ready
    output logic pslverr,                   // apb error
    input wire logic [$clog2(DEPTH)-1:0] a_addr, // port a address
    input wire logic [WIDTH-1:0] a_wdata,   // port a write data
    input wire logic a_wren,                // port a write enable
    input wire logic a_rden,                // port a read enable
    output logic [WIDTH-1:0] a_rdata,       // port a read data
    input wire logic [$clog2(DEPTH)-1:0] b_addr, // port b address
    input wire logic [WIDTH-1:0] b_wdata,   // port b write data
    input wire logic b_wren,                // port b write enable
    input wire logic b_rden,                // port b read enable
    output logic [WIDTH-1:0] b_rdata,       // port b read data
    input wire logic [WIDTH-1:0] sh_in,     // shift data in
    input wire logic sh_en,                 // shift step
    output logic [TAPS*WIDTH-1:0] sh_taps,  // tap words
    output logic [WIDTH-1:0] sh_out,        // last tap, for chaining
    input wire logic f_in_valid,            // fifo push valid
    input wire logic [WIDTH-1:0] f_in_data, // fifo push data
    output logic f_in_ready,                // fifo push ready
    output logic f_out_valid,               // fifo pop valid
    output logic [WIDTH-1:0] f_out_data,    // fifo pop data
    input wire logic f_out_ready,           // fifo pop ready
    output logic cfg_error                  // illegal build setting
);
    import erm_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int SH_LEN = TAP_LEN * TAPS;
    localparam int LW = $clog2(ERM_FIFO_DEPTH) + 1;

    ////////////////////////////////////////////////////////////////////
    // build-time legality of the mode
    wire is_lut = (BLOCK == ERM_LUT);
    wire bad_tdp = is_lut && (MODE == ERM_TDP);
    wire bad_fifo = is_lut && (MODE == ERM_FIFO)
        && (FIFO_RD_W != WIDTH);
    wire ok = !(bad_tdp || bad_fifo);
    assign cfg_error = !ok;

    // mode decode, mode never changes after build
    wire m_sp = (MODE == ERM_SP);
    wire m_sdp = (MODE == ERM_SDP);
    wire m_tdp = (MODE == ERM_TDP);
    wire m_sh = (MODE == ERM_SHIFT);
    wire m_rom = (MODE == ERM_ROM);
    wire m_fifo = (MODE == ERM_FIFO);

    ////////////////////////////////////////////////////////////////////
    // software registers
    logic [31:0] ctrl;
    logic [15:0] wr_cnt;
    logic [15:0] rd_cnt;
    wire [LW-1:0] f_level;
    wire oreg = ctrl[ERM_CTRL_OREG_BIT];
    wire [1:0] rdw_sel = ctrl[ERM_CTRL_RDW_LSB +: 2];

    // enables with the read enable port optionally absent
    wire a_rd_req = HAS_RDEN ? a_rden : 1'b1;
    wire b_rd_req = HAS_RDEN ? b_rden : 1'b1;

    // write and read qualifiers per port
    wire wr_a = ok && a_wren && (m_sp || m_sdp || m_tdp);
    wire wr_b = ok && b_wren && m_tdp;
    wire rd_a = ok && a_rd_req && (m_sp || m_tdp);
    wire rd_b = ok && b_rd_req && (m_sdp || m_tdp);
    wire rom_ld = ok && a_rd_req && m_rom;
    wire sh_step = ok && sh_en && m_sh;

    ////////////////////////////////////////////////////////////////////
    // storage and initial image
    logic [WIDTH-1:0] mem [DEPTH];

    function automatic logic [WIDTH-1:0] init_word(input int i);
        logic [31:0] v;
        v = ERM_ROM_SEED ^ 32'(i);
        init_word = (MODE == ERM_ROM) ? WIDTH'(v) : '0;
    endfunction : init_word

    // memory writes; port a wins a same-address double write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) mem[i] <= init_word(i);
        end else if (sh_step) begin
            mem[0] <= sh_in;
            for (int i = 1; i < SH_LEN; i++) mem[i] <= mem[i-1];
        end else begin
            if (wr_b) mem[b_addr] <= b_wdata;
            if (wr_a) mem[a_addr] <= a_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // port a read data, with read-during-write choice
    wire [WIDTH-1:0] a_word = mem[a_addr];
    wire [WIDTH-1:0] b_word = mem[b_addr];
    wire [WIDTH-1:0] a_rdw_word =
        (rdw_sel == ERM_RDW_NEW) ? a_wdata :
        (rdw_sel == ERM_RDW_OLD) ? a_word : DC_WORD;
    wire [WIDTH-1:0] next_a_q = wr_a ? a_rdw_word : a_word;
    wire clr_n = presetn && !out_aclr;
    logic [WIDTH-1:0] a_q;
    logic [WIDTH-1:0] b_q;

    // port a output register; held while the read enable is low
    always_ff @(posedge pclk or negedge clr_n) begin
        if (!clr_n) a_q <= '0;
        else if (rd_a) a_q <= next_a_q;
    end

    // port b output register; old word on a cross-port collision
    always_ff @(posedge pclk or negedge clr_n) begin
        if (!clr_n) b_q <= '0;
        else if (rd_b) b_q <= b_word;
    end

    ////////////////////////////////////////////////////////////////////
    // rom path: address stage, optional bypass on the lut block
    wire addr_unreg = is_lut && ROM_ADDR_UNREG;
    logic [AW-1:0] rom_addr_q;
    logic rom_v;
    logic [WIDTH-1:0] rom_q;
    wire [AW-1:0] rom_addr = addr_unreg ? a_addr : rom_addr_q;
    wire [WIDTH-1:0] rom_word = mem[rom_addr];
    wire rom_cap = addr_unreg ? rom_ld : rom_v;

    // rom address register and its valid flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_addr_q <= '0;
            rom_v <= 1'b0;
        end else begin
            if (rom_ld) rom_addr_q <= a_addr;
            rom_v <= rom_ld;
        end
    end

    // rom output register, cleared asynchronously by out_aclr like the port a and b registers
    always_ff @(posedge pclk or negedge clr_n) begin
        if (!clr_n) rom_q <= '0;
        else if (rom_cap) rom_q <= rom_word;
    end

    // output selection per mode
    wire [WIDTH-1:0] rom_out = oreg ? rom_q : rom_word;
    assign a_rdata = m_rom ? rom_out : a_q;
    assign b_rdata = b_q;

    ////////////////////////////////////////////////////////////////////
    // shift taps, one word at the end of each tap
    genvar t;
    generate
        for (t = 0; t < TAPS; t++) begin : g_tap
            assign sh_taps[t*WIDTH +: WIDTH] =
                mem[(t + 1) * TAP_LEN - 1];
        end
    endgenerate
    assign sh_out = mem[SH_LEN - 1];

    ////////////////////////////////////////////////////////////////////
    // fifo storage, only live in fifo mode on a legal build
    wire fifo_on = ok && m_fifo;
    erm_stream_if #(.W(WIDTH)) fifo_in ();
    erm_stream_if #(.W(WIDTH)) fifo_out ();

    assign fifo_in.valid = f_in_valid && fifo_on;
    assign fifo_in.data = f_in_data;
    assign f_in_ready = fifo_in.ready && fifo_on;
    assign f_out_valid = fifo_out.valid && fifo_on;
    assign f_out_data = fifo_out.data;
    assign fifo_out.ready = f_out_ready && fifo_on;

    // the fifo buffer itself
    erm_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(ERM_FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .wr(fifo_in),
        .rd(fifo_out),
        .level(f_level)
    );

    ////////////////////////////////////////////////////////////////////
    // operation counters
    wire [15:0] wr_inc = 16'(wr_a) + 16'(wr_b);
    wire [15:0] rd_inc = 16'(rd_a) + 16'(rd_b) + 16'(rom_ld);

    // apb decode
    wire acc = psel && penable;
    wire hit_ctrl = (paddr == ERM_CTRL_OFF);
    wire hit_stat = (paddr == ERM_STAT_OFF);
    wire hit_cnt = (paddr == ERM_CNT_OFF);
    wire hit_any = hit_ctrl || hit_stat || hit_cnt;
    wire wr_ctrl = acc && pwrite && hit_ctrl;
    wire clr_cnt = acc && pwrite && hit_cnt;

    // control register and counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ERM_CTRL_RST;
            wr_cnt <= '0;
            rd_cnt <= '0;
        end else begin
            if (wr_ctrl) ctrl <= pwdata & 32'h0000_0007;
            wr_cnt <= clr_cnt ? wr_inc : wr_cnt + wr_inc;
            rd_cnt <= clr_cnt ? rd_inc : rd_cnt + rd_inc;
        end
    end

    // status word
    logic [31:0] stat;
    always_comb begin
        stat = '0;
        stat[ERM_STAT_MODE_LSB +: 3] = MODE;
        stat[ERM_STAT_BLK_LSB +: 2] = BLOCK;
        stat[ERM_STAT_ERR_BIT] = cfg_error;
        stat[ERM_STAT_LVL_LSB +: LW] = f_level;
    end

    // read mux and answer
    wire [31:0] cnt_word = {rd_cnt, wr_cnt};
    assign prdata = hit_ctrl ? ctrl :
                    hit_stat ? stat :
                    hit_cnt ? cnt_word : 32'h0000_0000;
    assign pready = 1'b1;
    assign pslverr = acc && !hit_any;

endmodule : erm_top

// >>> verif/erm_checker.sv
`timescale 1ns/1ps
module erm_checker #(
    parameter erm_pkg::erm_mode_t MODE = erm_pkg::ERM_SP,
    parameter erm_pkg::erm_blk_t BLOCK = erm_pkg::ERM_LARGE,
    parameter int WIDTH = 16,
    parameter int FIFO_RD_W = 16,
    parameter bit HAS_RDEN = 1'b1
) (
    input wire logic pclk,                // clock
    input wire logic presetn,             // async reset, active low
    input wire logic out_aclr,            // output clear
    input wire logic a_wren,              // port a write
    input wire logic a_rden,              // port a read
    input wire logic [WIDTH-1:0] a_rdata, // port a data
    input wire logic f_in_valid,          // push valid
    input wire logic f_in_ready,          // push ready
    input wire logic f_out_valid,         // pop valid
    input wire logic f_out_ready,         // pop ready
    input wire logic [WIDTH-1:0] f_out_data, // pop data
    input wire logic cfg_error            // illegal build
);
    import erm_pkg::*;
    localparam bit BAD = (BLOCK == ERM_LUT) && ((MODE == ERM_TDP) ||
        (MODE == ERM_FIFO && FIFO_RD_W != WIDTH));
    // fifo only runs on a legal build
    localparam bit FON = (MODE == ERM_FIFO) && !BAD;
    // port a output is a register outside rom mode
    localparam bit OREG_ON = (MODE != ERM_ROM);
    // hold on write needs a read enable port
    localparam bit HOLD_ON = OREG_ON && HAS_RDEN;
    logic [3:0] occ;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // words held, counted from handshakes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) occ <= 4'h0;
        else occ <= occ + 4'(f_in_valid && f_in_ready)
            - 4'(f_out_valid && f_out_ready);
    end

    ////////////////////////////////////////////////////////////////////////
    property p_rdw_hold;
        HOLD_ON && a_wren && !a_rden && !out_aclr
            |=> out_aclr || $stable(a_rdata);
    endproperty
    a_rdw_hold: assert property (p_rdw_hold) else $error("output moved");
    property p_aclr;
        OREG_ON && out_aclr |-> a_rdata == '0;
    endproperty
    a_aclr: assert property (p_aclr) else $error("clear missed");
    property p_aclr_rel;
        OREG_ON && $fell(out_aclr) |-> a_rdata == '0;
    endproperty
    a_aclr_rel: assert property (p_aclr_rel) else $error("clear lost");
    property p_fifo_gate;
        !FON |-> !f_in_ready && !f_out_valid;
    endproperty
    a_fifo_gate: assert property (p_fifo_gate) else $error("fifo live");
    property p_fifo_vld;
        FON |-> f_out_valid == (occ != 4'h0);
    endproperty
    a_fifo_vld: assert property (p_fifo_vld) else $error("bad valid");
    property p_fifo_full;
        FON |-> f_in_ready == (occ != 4'h8);
    endproperty
    a_fifo_full: assert property (p_fifo_full) else $error("bad ready");
    property p_fifo_stall;
        f_out_valid && !f_out_ready |=> f_out_valid && $stable(f_out_data);
    endproperty
    a_fifo_stall: assert property (p_fifo_stall) else $error("head lost");
    property p_cfg;
        cfg_error == BAD;
    endproperty
    a_cfg: assert property (p_cfg) else $error("bad cfg flag");
endmodule : erm_checker

bind erm_top erm_checker #(.MODE(MODE), .BLOCK(BLOCK), .WIDTH(WIDTH),
    .FIFO_RD_W(FIFO_RD_W), .HAS_RDEN(HAS_RDEN)) erm_checker_inst (
    .pclk(pclk), .presetn(presetn),
    .out_aclr(out_aclr), .a_wren(a_wren), .a_rden(a_rden), .a_rdata(a_rdata),
    .f_in_valid(f_in_valid), .f_in_ready(f_in_ready),
    .f_out_valid(f_out_valid), .f_out_ready(f_out_ready),
    .f_out_data(f_out_data), .cfg_error(cfg_error));

// >>> verif/erm_fabric_sink.sv
`timescale 1ns/1ps
module erm_fabric_sink (
    input wire logic pclk,     // clock
    input wire logic presetn,  // async reset, active low
    input wire logic stall,    // hold off draining
    output logic f_out_ready   // pop ready
);
    // fabric consumer, drains with random gaps
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) f_out_ready <= 1'b0;
        else f_out_ready <= !stall && ($urandom % 3 != 0);
    end
endmodule : erm_fabric_sink

// >>> verif/embedded_ram_mode_block_tb.sv
`timescale 1ns/1ps
module embedded_ram_mode_block_tb;
    import erm_pkg::*;
    logic pclk, presetn, out_aclr, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, prdata_f, rd, rdf;
    logic [4:0] a_addr;
    logic [15:0] a_wdata, a_rdata, f_in_data, f_out_data_f;
    logic a_wren, a_rden, f_in_valid, f_in_ready_f, f_out_valid_f;
    logic f_out_ready, stall, err, rd_pend;
    logic [63:0] sh_taps_s;
    logic [15:0] mem [32];
    logic [15:0] exp_a [$];
    logic [15:0] exp_f [$];
    int n_fail, n_compared;

    erm_top erm_top_inst (.pclk(pclk), .presetn(presetn), .out_aclr(out_aclr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .a_addr(a_addr), .a_wdata(a_wdata), .a_wren(a_wren), .a_rden(a_rden),
        .a_rdata(a_rdata), .b_addr(a_addr), .b_wdata(a_wdata),
        .b_wren(a_wren), .b_rden(a_rden), .b_rdata(), .sh_in(a_wdata),
        .sh_en(a_wren), .sh_taps(), .sh_out(), .f_in_valid(f_in_valid),
        .f_in_data(f_in_data), .f_in_ready(), .f_out_valid(), .f_out_data(),
        .f_out_ready(f_out_ready), .cfg_error());
    erm_top #(.MODE(ERM_FIFO)) erm_top_fifo_inst (.pclk(pclk),
        .presetn(presetn), .out_aclr(out_aclr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_f), .pready(), .pslverr(), .a_addr(a_addr),
        .a_wdata(a_wdata), .a_wren(a_wren), .a_rden(a_rden), .a_rdata(),
        .b_addr(a_addr), .b_wdata(a_wdata), .b_wren(a_wren), .b_rden(a_rden),
        .b_rdata(), .sh_in(a_wdata), .sh_en(a_wren), .sh_taps(), .sh_out(),
        .f_in_valid(f_in_valid), .f_in_data(f_in_data),
        .f_in_ready(f_in_ready_f), .f_out_valid(f_out_valid_f),
        .f_out_data(f_out_data_f), .f_out_ready(f_out_ready), .cfg_error());
    erm_top #(.MODE(ERM_SHIFT)) erm_top_shift_inst (.pclk(pclk),
        .presetn(presetn), .out_aclr(out_aclr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(), .pready(), .pslverr(), .a_addr(a_addr),
        .a_wdata(a_wdata), .a_wren(a_wren), .a_rden(a_rden), .a_rdata(),
        .b_addr(a_addr), .b_wdata(a_wdata), .b_wren(a_wren), .b_rden(a_rden),
        .b_rdata(), .sh_in(a_wdata), .sh_en(a_wren), .sh_taps(sh_taps_s),
        .sh_out(), .f_in_valid(f_in_valid), .f_in_data(f_in_data),
        .f_in_ready(), .f_out_valid(), .f_out_data(),
        .f_out_ready(f_out_ready), .cfg_error());
    erm_fabric_sink erm_fabric_sink_inst (.pclk(pclk), .presetn(presetn),
        .stall(stall), .f_out_ready(f_out_ready));

    ////////////////////////////////////////////////////////////////////////
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task final_report;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    // one apb transfer, answer taken at the ready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rdf = prdata_f;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // port a request for one cycle, read result noted
    task aop(input logic w, r, input logic [4:0] a, input logic [15:0] d, e);
        a_addr <= a;
        a_wdata <= d;
        a_wren <= w;
        a_rden <= r;
        if (r) exp_a.push_back(e);
        @(posedge pclk);
    endtask : aop

    // push one word, valid stays up for the next
    task push(input logic [15:0] d);
        f_in_data <= d;
        @(negedge pclk);
        while (f_in_ready_f !== 1'b1) @(negedge pclk);
        exp_f.push_back(d);
        @(posedge pclk);
    endtask : push

    // result watcher, oldest note first
    always @(posedge pclk) begin
        if (rd_pend && exp_a.size() != 0)
            cmp(32'(a_rdata), 32'(exp_a.pop_front()));
        if (f_out_valid_f === 1'b1 && f_out_ready === 1'b1 && exp_f.size())
            cmp(32'(f_out_data_f), 32'(exp_f.pop_front()));
        rd_pend <= (a_rden === 1'b1);
    end

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [4:0] a;
        logic [15:0] d, e;
        void'($urandom(30));
        {psel, penable, pwrite, paddr, pwdata, out_aclr} = '0;
        {a_addr, a_wdata, a_wren, a_rden, f_in_valid, f_in_data} = '0;
        {n_fail, n_compared} = '0;
        stall = 1'b1;
        presetn = 1'b0;
        foreach (mem[i]) mem[i] = 16'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ERM_CTRL_OFF, 32'h0);
        cmp(rd, ERM_CTRL_RST);
        apb(1'b1, ERM_STAT_OFF, 32'hffff_ffff);
        apb(1'b0, ERM_STAT_OFF, 32'h0);
        cmp(rd, 32'(ERM_SP));
        apb(1'b0, 12'h00c, 32'h0);
        cmp(rd | 32'(err), 32'h1);
        for (int i = 0; i < 8; i++) begin
            mem[i] = 16'($urandom);
            aop(1'b1, 1'b0, 5'(i), mem[i], 16'h0);
        end
        for (int i = 0; i < 8; i++) aop(1'b0, 1'b1, 5'(i), 16'h0, mem[i]);
        cmp(sh_taps_s[31:0], {mem[0], mem[4]});
        d = mem[7];
        mem[7] = ~mem[7];
        aop(1'b1, 1'b0, 5'd7, mem[7], 16'h0);
        a_wren <= 1'b0;
        @(posedge pclk);
        cmp(32'(a_rdata), 32'(d));
        out_aclr <= 1'b1;
        @(posedge pclk);
        out_aclr <= 1'b0;
        @(posedge pclk);
        cmp(32'(a_rdata), 32'h0);
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, ERM_CTRL_OFF, (32'(r) << ERM_CTRL_RDW_LSB) | 32'h1);
            a = 5'($urandom);
            d = 16'($urandom);
            e = (r == 0) ? d : (r == 1) ? mem[a] : 16'hffff;
            aop(1'b1, 1'b1, a, d, e);
            mem[a] = d;
            aop(1'b0, 1'b1, a, 16'h0, d);
            a_rden <= 1'b0;
            @(posedge pclk);
        end
        f_in_valid <= 1'b1;
        for (int i = 0; i < 8; i++) push(16'($urandom));
        @(negedge pclk);
        cmp(32'(f_in_ready_f), 32'h0);
        @(posedge pclk);
        f_in_valid <= 1'b0;
        apb(1'b0, ERM_STAT_OFF, 32'h0);
        cmp(rdf, 32'(ERM_FIFO) | (32'(8) << ERM_STAT_LVL_LSB));
        stall <= 1'b0;
        for (int t = 0; t < 200 && exp_f.size() != 0; t++) @(posedge pclk);
        cmp(32'(exp_f.size()), 32'h0);
        final_report();
    end
endmodule : embedded_ram_mode_block_tb
